// ---- logic/nand_host_pkg.sv ----
// Purpose: Constants and types for the NAND flash host controller
// Assumes: 20 MHz core clock, AXI4-Lite register access
// Notes:   All pin timing counts derive from nanosecond figures below
// What this block does
// - Command byte latched on write rise, command latch high
// - Address byte latched on write rise, address latch high
// - Guard low inhibits; host holds it during busy
// - Full address sent as four bytes, column then row; column-only or row-only address as two bytes
// - Latch levels select command, address, data cycles
// - Read busy, select low: keep strobes high
// - Software, not the host, reads the four sector ECC statuses
// - At most four partial programs per page; software keeps the count, the host does not
package nand_host_pkg;
   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS   = 50;
   localparam int WRITE_LOW_NS    = 12;
   localparam int CS_SETUP_NS     = 20;
   localparam int READ_ACCESS_NS  = 20;
   localparam int BUS_GAP_NS      = 100;
   localparam int SYNC_STAGES     = 3;
   localparam int CNT_W           = 3;

   function automatic int ceil_cyc(input int ns);
      ceil_cyc = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      if (ceil_cyc < 1) ceil_cyc = 1;
   endfunction

   localparam int WR_LOW_CYC = ceil_cyc(WRITE_LOW_NS);
   localparam int RD_LOW_CYC = ceil_cyc(READ_ACCESS_NS) + SYNC_STAGES;
   localparam int SETUP_CYC  = ceil_cyc(CS_SETUP_NS);
   localparam int GAP_CYC    = ceil_cyc(BUS_GAP_NS);

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam int         AXI_AW      = 8;
   localparam logic [7:0] REG_CTRL    = 8'h00;
   localparam logic [7:0] REG_ADDR    = 8'h04;
   localparam logic [7:0] REG_OP      = 8'h08;
   localparam logic [7:0] REG_STATUS  = 8'h0C;
   localparam int CTRL_CS_BIT    = 0;
   localparam int CTRL_GUARD_BIT = 1;
   localparam int COL_LSB        = 0;
   localparam int COL_W          = 12;
   localparam int ROW_LSB        = 16;
   localparam int ROW_W          = 16;
   localparam int OP_KIND_LSB    = 8;
   localparam int ST_BUSY_BIT    = 0;
   localparam int ST_READY_BIT   = 1;
   localparam int ST_DATA_LSB    = 8;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] BEAT_COL0   = 2'h0;
   localparam logic [1:0] BEAT_COL1   = 2'h1;
   localparam logic [1:0] BEAT_ROW0   = 2'h2;
   localparam logic [1:0] BEAT_ROW1   = 2'h3;

   typedef enum logic [2:0] {
      K_CMD, K_ADDR_FULL, K_ADDR_COL, K_ADDR_ROW, K_DATA_WR, K_DATA_RD, K_WAIT_READY
   } op_kind_t;

   typedef struct packed {
      op_kind_t   kind;
      logic [7:0] data;
   } op_t;

   // Byte of the address for one address beat
   function automatic logic [7:0] addr_byte(input logic [1:0] beat,
                                            input logic [COL_W-1:0] col,
                                            input logic [ROW_W-1:0] row);
      case (beat)
         BEAT_COL0: addr_byte = col[7:0];
         BEAT_COL1: addr_byte = {4'h0, col[11:8]};
         BEAT_ROW0: addr_byte = row[7:0];
         default:   addr_byte = row[15:8];
      endcase
   endfunction
endpackage

// ---- logic/nand_host.sv ----
// Purpose: AXI4-Lite driven host controller for an asynchronous NAND flash
// Assumes: Software sequences commands, addresses and data one operation at a time
// Notes:   Every pin output is registered; ready pin and data inputs are synchronised
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
module nand_host
   import nand_host_pkg::*;
(
   input  wire logic              i_core_clk,
   input  wire logic              i_sys_rst,
   input  wire logic              i_s_axi_awvalid,
   output      logic              o_s_axi_awready,
   input  wire logic [AXI_AW-1:0] i_s_axi_awaddr,
   input  wire logic              i_s_axi_wvalid,
   output      logic              o_s_axi_wready,
   input  wire logic [31:0]       i_s_axi_wdata,
   input  wire logic [3:0]        i_s_axi_wstrb,
   output      logic              o_s_axi_bvalid,
   input  wire logic              i_s_axi_bready,
   output      logic [1:0]        o_s_axi_bresp,
   input  wire logic              i_s_axi_arvalid,
   output      logic              o_s_axi_arready,
   input  wire logic [AXI_AW-1:0] i_s_axi_araddr,
   output      logic              o_s_axi_rvalid,
   input  wire logic              i_s_axi_rready,
   output      logic [31:0]       o_s_axi_rdata,
   output      logic [1:0]        o_s_axi_rresp,
   output      logic              o_cmd_latch,
   output      logic              o_addr_latch,
   output      logic              o_chip_sel_n,
   output      logic              o_write_strobe_n,
   output      logic              o_read_strobe_n,
   output      logic              o_write_guard_n,
   output      logic [7:0]        o_io_port,
   output      logic              o_io_port_oe,
   input  wire logic [7:0]        i_io_port,
   input  wire logic              i_ready_busy_n
);
   // ****************************************************************
   // Synchronisers
   // ****************************************************************
   logic [SYNC_STAGES-1:0] rdy_sync;
   logic                   rdy;
   logic [7:0]             io_s1, io_s2, io_s3;

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         rdy_sync <= '0;
         rdy      <= 1'b0;
         io_s1    <= 8'h00;
         io_s2    <= 8'h00;
         io_s3    <= 8'h00;
      end else begin
         rdy_sync <= {rdy_sync[SYNC_STAGES-2:0], i_ready_busy_n};
         if (rdy_sync[1] == rdy_sync[2]) rdy <= rdy_sync[2];
         io_s1    <= i_io_port;
         io_s2    <= io_s1;
         io_s3    <= io_s2;
      end
   end

   // ****************************************************************
   // Registers and AXI4-Lite slave
   // ****************************************************************
   typedef enum {S_IDLE, S_SETUP, S_LOW, S_GAP, S_WAIT_READY} state_t;
   state_t            state;
   logic [31:0]       ctrl, addr;
   op_t               op;
   logic [7:0]        rd_byte;
   logic              aw_got, w_got;
   logic [AXI_AW-1:0] aw_q;
   logic [31:0]       wd_q;
   logic [3:0]        ws_q;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      for (int i = 0; i < 4; i++) merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
   endfunction

   wire        wr_fire  = aw_got && w_got && !o_s_axi_bvalid;
   wire        wr_ctrl  = wr_fire && (aw_q == REG_CTRL);
   wire        wr_addr  = wr_fire && (aw_q == REG_ADDR);
   wire        wr_op    = wr_fire && (aw_q == REG_OP);
   wire        op_start = wr_op && (state == S_IDLE);
   wire        wr_ok    = wr_ctrl || wr_addr || op_start;
   wire [31:0] op_word  = merge(32'h0000_0000, wd_q, ws_q);
   wire        ar_fire  = i_s_axi_arvalid && o_s_axi_arready;
   wire        busy     = (state != S_IDLE);
   wire [31:0] status   = ({24'h00_0000, rd_byte} << ST_DATA_LSB)
                        | ({31'h0, rdy} << ST_READY_BIT) | ({31'h0, busy} << ST_BUSY_BIT);
   wire        rd_map   = (i_s_axi_araddr == REG_CTRL) || (i_s_axi_araddr == REG_ADDR)
                        || (i_s_axi_araddr == REG_STATUS);
   wire [31:0] rd_data  = (i_s_axi_araddr == REG_CTRL) ? ctrl :
                          (i_s_axi_araddr == REG_ADDR) ? addr :
                          (i_s_axi_araddr == REG_STATUS) ? status : 32'h0000_0000;

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_s_axi_awready <= 1'b1;
         o_s_axi_wready  <= 1'b1;
         o_s_axi_bvalid  <= 1'b0;
         o_s_axi_bresp   <= RESP_OKAY;
         o_s_axi_arready <= 1'b1;
         o_s_axi_rvalid  <= 1'b0;
         o_s_axi_rdata   <= 32'h0000_0000;
         o_s_axi_rresp   <= RESP_OKAY;
         aw_got <= 1'b0;
         w_got  <= 1'b0;
         aw_q   <= '0;
         wd_q   <= 32'h0000_0000;
         ws_q   <= 4'h0;
         ctrl   <= 32'h0000_0000;
         addr   <= 32'h0000_0000;
      end else begin
         if (i_s_axi_awvalid && o_s_axi_awready) begin
            aw_q            <= i_s_axi_awaddr;
            aw_got          <= 1'b1;
            o_s_axi_awready <= 1'b0;
         end
         if (i_s_axi_wvalid && o_s_axi_wready) begin
            wd_q           <= i_s_axi_wdata;
            ws_q           <= i_s_axi_wstrb;
            w_got          <= 1'b1;
            o_s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            aw_got         <= 1'b0;
            w_got          <= 1'b0;
            o_s_axi_bvalid <= 1'b1;
            o_s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         if (o_s_axi_bvalid && i_s_axi_bready) begin
            o_s_axi_bvalid  <= 1'b0;
            o_s_axi_awready <= 1'b1;
            o_s_axi_wready  <= 1'b1;
         end
         if (wr_ctrl) ctrl <= merge(ctrl, wd_q, ws_q);
         if (wr_addr) addr <= merge(addr, wd_q, ws_q);
         if (ar_fire) begin
            o_s_axi_arready <= 1'b0;
            o_s_axi_rvalid  <= 1'b1;
            o_s_axi_rdata   <= rd_data;
            o_s_axi_rresp   <= rd_map ? RESP_OKAY : RESP_SLVERR;
         end
         if (o_s_axi_rvalid && i_s_axi_rready) begin
            o_s_axi_rvalid  <= 1'b0;
            o_s_axi_arready <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // Pin sequencer
   // ****************************************************************
   logic [CNT_W-1:0] cnt;
   logic [1:0]       beat, last_beat;

   wire [COL_W-1:0] col_addr  = addr[COL_LSB +: COL_W];
   wire [ROW_W-1:0] row_addr  = addr[ROW_LSB +: ROW_W];
   wire op_t        new_op    = '{kind: op_kind_t'(op_word[OP_KIND_LSB +: 3]), data: op_word[7:0]};
   wire             is_addr   = (new_op.kind == K_ADDR_FULL) || (new_op.kind == K_ADDR_COL)
                              || (new_op.kind == K_ADDR_ROW);
   wire [1:0]       first_bt  = (new_op.kind == K_ADDR_ROW) ? BEAT_ROW0 : BEAT_COL0;
   wire [1:0]       end_bt    = (new_op.kind == K_ADDR_COL) ? BEAT_COL1 :
                                is_addr ? BEAT_ROW1 : BEAT_COL0;
   wire [7:0]       first_io  = is_addr ? addr_byte(first_bt, col_addr, row_addr) : new_op.data;
   wire             cnt_done  = (cnt == '0);
   // Sector status read count and partial program count are left to software
   wire             is_read   = (op.kind == K_DATA_RD);
   wire             next_act  = op_start || (state != S_IDLE);

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         state            <= S_IDLE;
         op               <= '{kind: K_CMD, data: 8'h00};
         cnt              <= '0;
         beat             <= 2'h0;
         last_beat        <= 2'h0;
         rd_byte          <= 8'h00;
         o_cmd_latch      <= 1'b0;
         o_addr_latch     <= 1'b0;
         o_chip_sel_n     <= 1'b1;
         o_write_strobe_n <= 1'b1;
         o_read_strobe_n  <= 1'b1;
         o_write_guard_n  <= 1'b0;
         o_io_port        <= 8'h00;
         o_io_port_oe     <= 1'b0;
      end else begin
         o_chip_sel_n <= !(ctrl[CTRL_CS_BIT] || next_act);
         // Guard only changes while the device is ready
         if (rdy) o_write_guard_n <= ctrl[CTRL_GUARD_BIT];
         case (state)
            S_IDLE: if (op_start) begin
               op        <= new_op;
               beat      <= first_bt;
               last_beat <= end_bt;
               cnt       <= CNT_W'(SETUP_CYC - 1);
               if (new_op.kind == K_WAIT_READY) begin
                  state <= S_WAIT_READY;
               end else begin
                  state        <= S_SETUP;
                  o_cmd_latch  <= (new_op.kind == K_CMD);
                  o_addr_latch <= is_addr;
                  o_io_port    <= first_io;
                  o_io_port_oe <= (new_op.kind != K_DATA_RD);
               end
            end
            S_SETUP: if (cnt_done) begin
               state <= S_LOW;
               // Read sample waits for access delay plus synchroniser depth
               cnt   <= is_read ? CNT_W'(RD_LOW_CYC - 1) : CNT_W'(WR_LOW_CYC - 1);
               if (is_read) o_read_strobe_n <= 1'b0;
               else o_write_strobe_n <= 1'b0;
            end else cnt <= cnt - 1'b1;
            S_LOW: if (cnt_done) begin
               state            <= S_GAP;
               cnt              <= CNT_W'(GAP_CYC - 1);
               o_write_strobe_n <= 1'b1;
               o_read_strobe_n  <= 1'b1;
               if (is_read) rd_byte <= io_s3;
            end else cnt <= cnt - 1'b1;
            S_GAP: if (!cnt_done) begin
               cnt <= cnt - 1'b1;
            end else if (beat != last_beat) begin
               beat      <= beat + 2'h1;
               o_io_port <= addr_byte(beat + 2'h1, col_addr, row_addr);
               cnt       <= CNT_W'(SETUP_CYC - 1);
               state     <= S_SETUP;
            end else begin
               o_cmd_latch  <= 1'b0;
               o_addr_latch <= 1'b0;
               o_io_port_oe <= 1'b0;
               state        <= S_IDLE;
            end
            // Strobes stay high while waiting on the busy device
            S_WAIT_READY: if (rdy) state <= S_IDLE;
            default: state <= S_IDLE;
         endcase
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   sequence s_write_rise;
      $rose(o_write_strobe_n);
   endsequence
   sequence s_addr_hi_beat;
      $fell(o_write_strobe_n) && o_addr_latch && (beat == BEAT_COL1);
   endsequence

   property p_cmd_cycle;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      s_write_rise and $past(o_cmd_latch) |-> !$past(o_addr_latch) && !$past(o_chip_sel_n);
   endproperty
   a_cmd_cycle: assert property (p_cmd_cycle) else $error("command cycle malformed");

   property p_addr_cycle;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      s_write_rise and $past(o_addr_latch) |-> !$past(o_cmd_latch) && !$past(o_chip_sel_n);
   endproperty
   a_addr_cycle: assert property (p_addr_cycle) else $error("address cycle malformed");

   property p_write_levels;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      $fell(o_write_strobe_n) |-> o_read_strobe_n && !o_chip_sel_n;
   endproperty
   a_write_levels: assert property (p_write_levels) else $error("write strobe levels");

   property p_data_guard;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      $fell(o_write_strobe_n) && !o_cmd_latch && !o_addr_latch |-> o_write_guard_n;
   endproperty
   a_data_guard: assert property (p_data_guard) else $error("data in with guard low");

   property p_guard_hold;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      !rdy |=> $stable(o_write_guard_n);
   endproperty
   a_guard_hold: assert property (p_guard_hold) else $error("guard moved while busy");

   property p_busy_strobes;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      (state == S_WAIT_READY) |-> o_write_strobe_n && o_read_strobe_n;
   endproperty
   a_busy_strobes: assert property (p_busy_strobes) else $error("strobe low while busy");

   property p_strobe_gap;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      s_write_rise |-> o_write_strobe_n [*3];
   endproperty
   a_strobe_gap: assert property (p_strobe_gap) else $error("strobe high too short");

   property p_addr_upper;
      @(posedge i_core_clk) disable iff (i_sys_rst)
      s_addr_hi_beat |-> (o_io_port[7:4] == 4'h0) ##1 $rose(o_write_strobe_n) && $stable(o_io_port);
   endproperty
   a_addr_upper: assert property (p_addr_upper) else $error("column high byte bad");

endmodule // nand_host

// ---- tb/nand_dev_model.sv ----
// Purpose: Behavioural flash device seen from the host pins
// Assumes: Busy times shortened by parameters
// Notes:   Released data lines show the inverse of the last byte
`timescale 1ns/10ps
module nand_dev_model #(
   parameter int         T_LOAD  = 8000,
   parameter int         T_PROG  = 6000,
   parameter int         T_ERASE = 9000,
   parameter logic [7:0] ID0     = 8'h5A, // Arbitrary value
   parameter logic [7:0] ID1     = 8'hC3  // Arbitrary value
) (
   input  wire logic       i_cmd_latch,
   input  wire logic       i_addr_latch,
   input  wire logic       i_chip_sel_n,
   input  wire logic       i_write_strobe_n,
   input  wire logic       i_read_strobe_n,
   input  wire logic       i_write_guard_n,
   input  wire logic [7:0] i_io_port,
   output      logic [7:0] o_io_port,
   output      logic       o_io_oe,
   output      logic       o_busy
);
   logic [7:0]  mem [int];
   logic [7:0]  page_buf [2112];
   logic [7:0]  dout;
   logic [11:0] col  = 12'h000;
   logic [15:0] row  = 16'h0000;
   logic [1:0]  mode = 2'h0;
   logic        fail = 1'b0;
   int          beat = 0;
   int          viol = 0;
   int          loads = 0;
   int          dly = 0;
   event        go;
   wire         standby = i_chip_sel_n && !o_busy;
   wire         ok = !o_busy || (i_cmd_latch && (i_io_port == 8'h70 || i_io_port == 8'hFF));
   initial begin
      o_busy = 1'b0;
      o_io_oe = 1'b0;
      o_io_port = 8'h00;
   end
   // ****
   // Command decode
   // ****
   always @(go) begin
      o_busy = 1'b1;
      #(dly);
      o_busy = 1'b0;
   end
   task automatic do_cmd(input logic [7:0] c);
      int base;
      base = row * 2112;
      beat = (c == 8'h60) ? 2 : 0;
      mode = (c == 8'h70) ? 2'h1 : (c == 8'h90) ? 2'h2 : 2'h0;
      if (c == 8'h80) foreach (page_buf[i]) page_buf[i] = 8'hFF;
      if (c == 8'h90) col = 12'h000;
      if (c == 8'h10 || c == 8'hD0) fail = !i_write_guard_n;
      dly = (c == 8'h10) ? T_PROG : (c == 8'hD0) ? T_ERASE : T_LOAD;
      if (c == 8'h30 || c == 8'h35) begin
         loads++;
         foreach (page_buf[i]) page_buf[i] = mem.exists(base + i) ? mem[base + i] : 8'hFF;
         -> go;
      end
      if (c == 8'h10) begin
         if (i_write_guard_n) foreach (page_buf[i]) mem[base + i] = page_buf[i];
         -> go;
      end
      if (c == 8'hD0) begin
         base = {row[15:6], 6'h00} * 2112;
         if (i_write_guard_n) for (int i = 0; i < 64 * 2112; i++) mem.delete(base + i);
         -> go;
      end
   endtask
   always @(posedge i_write_strobe_n) begin
      if (!i_chip_sel_n && ok) begin
         if (!i_read_strobe_n || (i_cmd_latch && i_addr_latch)) viol++;
         if (o_io_oe) viol++;
         if (i_cmd_latch) do_cmd(i_io_port);
         else if (i_addr_latch) begin
            if (beat == 1 && i_io_port[7:4] != 4'h0) viol++;
            case (beat)
               0: col[7:0] = i_io_port;
               1: col[11:8] = i_io_port[3:0];
               2: row[7:0] = i_io_port;
               default: row[15:8] = i_io_port;
            endcase
            beat++;
         end else if (!i_write_guard_n) viol++;
         else begin
            page_buf[col] = i_io_port;
            col++;
         end
      end
   end
   always @(negedge i_read_strobe_n) begin
      if (!i_chip_sel_n) begin
         if (o_busy && mode != 2'h1) viol++;
         if (mode == 2'h1) dout = {1'b0, !o_busy, 5'h00, fail};
         else if (mode == 2'h2) dout = col[0] ? ID1 : ID0;
         else dout = page_buf[col];
         col++;
         #20;
         o_io_port = dout;
         o_io_oe = 1'b1;
      end
   end
   always @(posedge i_read_strobe_n) begin
      #25;
      o_io_oe = 1'b0;
      o_io_port = ~o_io_port;
   end
   // Short read high time: outputs stay on until a latch, select or write edge
   always @(posedge i_cmd_latch or posedge i_addr_latch or posedge i_chip_sel_n
            or negedge i_write_strobe_n) o_io_oe = 1'b0;
   always @(negedge i_write_guard_n) if (o_busy) viol++;
endmodule // nand_dev_model

// ---- tb/tb_nand_host.sv ----
// Purpose: Self-checking bench for the flash host controller
// Assumes: Device model with shortened busy times
// Notes:   Registers reached over AXI4-Lite only
`timescale 1ns/10ps
module tb_nand_host
   import nand_host_pkg::*;
;
   logic i_core_clk = 1'b0, i_sys_rst = 1'b1, i_s_axi_bready = 1'b1, i_s_axi_rready = 1'b1;
   logic i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_arvalid = 1'b0;
   logic [7:0] i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00, o_io_port, dev_io;
   logic [31:0] i_s_axi_wdata = 32'h0, o_s_axi_rdata, st;
   logic [3:0] i_s_axi_wstrb = 4'hF;
   logic [1:0] o_s_axi_bresp, o_s_axi_rresp, r;
   logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
   logic o_cmd_latch, o_addr_latch, o_chip_sel_n, o_write_strobe_n, o_read_strobe_n;
   logic o_write_guard_n, o_io_port_oe, dev_oe, dev_busy;
   wire [7:0] i_io_port = o_io_port_oe ? o_io_port : dev_io;
   wire i_ready_busy_n = !dev_busy; // Pull-up
   int failures = 0, n_checks = 0;
   always #25 i_core_clk = ~i_core_clk;
   nand_host DUT (.*);
   nand_dev_model mdl (.i_cmd_latch(o_cmd_latch), .i_addr_latch(o_addr_latch),
      .i_chip_sel_n(o_chip_sel_n), .i_write_strobe_n(o_write_strobe_n),
      .i_read_strobe_n(o_read_strobe_n), .i_write_guard_n(o_write_guard_n),
      .i_io_port(i_io_port), .o_io_port(dev_io), .o_io_oe(dev_oe), .o_busy(dev_busy));
   // ****
   // Shared tasks
   // ****
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic tmo;
      failures++;
      $display("BAD %0t wait ran out", $time);
      wrap_up();
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      i_s_axi_awvalid <= 1'b1;
      i_s_axi_awaddr <= a;
      i_s_axi_wvalid <= 1'b1;
      i_s_axi_wdata <= d;
      repeat (50) begin
         @(posedge i_core_clk);
         if (i_s_axi_awvalid && o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
         if (i_s_axi_wvalid && o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
         if (o_s_axi_bvalid) begin
            r = o_s_axi_bresp;
            return;
         end
      end
      tmo();
   endtask
   task automatic axi_rd(input logic [7:0] a);
      i_s_axi_arvalid <= 1'b1;
      i_s_axi_araddr <= a;
      repeat (50) begin
         @(posedge i_core_clk);
         if (i_s_axi_arvalid && o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
         if (o_s_axi_rvalid) begin
            st = o_s_axi_rdata;
            r = o_s_axi_rresp;
            return;
         end
      end
      tmo();
   endtask
   task automatic idle;
      repeat (400) begin
         axi_rd(REG_STATUS);
         if (st[ST_BUSY_BIT] === 1'b0) return;
      end
      tmo();
   endtask
   task automatic op(input op_kind_t k, input logic [7:0] b);
      axi_wr(REG_OP, {21'h0, k, b});
      chk(32'(r), 32'(RESP_OKAY));
      idle();
   endtask
   task automatic cmd(input logic [7:0] b);
      op(K_CMD, b);
   endtask
   task automatic rd_bytes(input logic [7:0] b0, input int n);
      for (int i = 0; i < n; i++) begin
         op(K_DATA_RD, 8'h00);
         chk(32'(st[15:8]), 32'(8'(b0 + i)));
      end
   endtask
   task automatic page(input logic [7:0] c, input logic [15:0] rw, input logic [11:0] cl);
      axi_wr(REG_ADDR, {rw, 4'h0, cl});
      if (c != 8'hFF) cmd(c);
      op(K_ADDR_FULL, 8'h00);
   endtask
   task automatic prog(input logic [15:0] rw, input logic [11:0] cl, input logic [7:0] b0, int n);
      page(8'h80, rw, cl);
      for (int i = 0; i < n; i++) op(K_DATA_WR, 8'(b0 + i));
      cmd(8'h10);
      op(K_WAIT_READY, 8'h00);
   endtask
   task automatic rd_chk(input logic [15:0] rw, input logic [11:0] cl, logic [7:0] b0, int n);
      page(8'h00, rw, cl);
      cmd(8'h30);
      op(K_WAIT_READY, 8'h00);
      rd_bytes(b0, n);
   endtask
   // ****
   // Scenarios
   // ****
   task automatic s_reset;
      chk(32'({o_chip_sel_n, o_write_strobe_n, o_cmd_latch, o_write_guard_n}), 32'hC);
      // Ready synchroniser restarts from busy after reset
      repeat (4) @(posedge i_core_clk);
      axi_rd(REG_STATUS);
      chk(32'(st[1:0]), 32'h2);
      axi_rd(8'h10);
      chk(32'(r), 32'(RESP_SLVERR));
      axi_wr(REG_STATUS, 32'h0);
      chk(32'(r), 32'(RESP_SLVERR));
   endtask
   task automatic s_prog;
      axi_wr(REG_CTRL, 32'h3);
      prog(16'h0041, 12'h7FE, 8'hA5, 4);
      chk(32'(mdl.row), 32'h41);
      prog(16'h003F, 12'h000, 8'h11, 2);
      rd_chk(16'h0041, 12'h7FE, 8'hA5, 4);
   endtask
   task automatic s_col;
      int l = mdl.loads;
      axi_wr(REG_ADDR, {16'h0041, 16'h07FF});
      cmd(8'h05);
      op(K_ADDR_COL, 8'h00);
      cmd(8'hE0);
      chk(32'(mdl.col), 32'h7FF);
      rd_bytes(8'hA6, 3);
      chk(32'(mdl.loads), 32'(l));
   endtask
   task automatic s_copy;
      page(8'h00, 16'h0041, 12'h000);
      cmd(8'h35);
      op(K_WAIT_READY, 8'h00);
      page(8'h85, 16'h0080, 12'h7FE);
      cmd(8'h10);
      op(K_WAIT_READY, 8'h00);
      rd_chk(16'h0080, 12'h7FE, 8'hA5, 4);
   endtask
   task automatic s_guard;
      // Data goes in with the guard high; it is low from the program start through the status and page reads
      page(8'h80, 16'h0042, 12'h000);
      op(K_DATA_WR, 8'h33);
      axi_wr(REG_CTRL, 32'h1);
      cmd(8'h10);
      op(K_WAIT_READY, 8'h00);
      chk(32'(o_write_guard_n), 32'h0);
      cmd(8'h70);
      rd_bytes(8'h41, 1);
      rd_chk(16'h0042, 12'h000, 8'hFF, 1);
   endtask
   task automatic s_hold;
      axi_wr(REG_CTRL, 32'h3);
      page(8'h80, 16'h0043, 12'h000);
      op(K_DATA_WR, 8'h77);
      cmd(8'h10);
      axi_wr(REG_CTRL, 32'h1);
      repeat (4) @(posedge i_core_clk);
      chk(32'(o_write_guard_n), 32'h1);
      op(K_WAIT_READY, 8'h00);
      axi_rd(REG_STATUS);
      chk(32'(o_write_guard_n), 32'h0);
      axi_wr(REG_CTRL, 32'h3);
   endtask
   task automatic s_busy;
      page(8'h00, 16'h0041, 12'h000);
      cmd(8'h30);
      axi_rd(REG_STATUS);
      chk(32'(st[ST_READY_BIT]), 32'h0);
      cmd(8'h70);
      cmd(8'h90);
      rd_bytes(8'h00, 1);
      axi_wr(REG_OP, {21'h0, K_WAIT_READY, 8'h00});
      axi_wr(REG_OP, {21'h0, K_CMD, 8'h70});
      chk(32'(r), 32'(RESP_SLVERR));
      idle();
      rd_bytes(8'h40, 1);
   endtask
   task automatic s_erase;
      axi_wr(REG_ADDR, {16'h0041, 16'h0000});
      cmd(8'h60);
      op(K_ADDR_ROW, 8'h00);
      cmd(8'hD0);
      op(K_WAIT_READY, 8'h00);
      rd_chk(16'h0043, 12'h000, 8'hFF, 1);
      rd_chk(16'h0080, 12'h7FE, 8'hA5, 1);
      rd_chk(16'h003F, 12'h000, 8'h11, 2);
   endtask
   task automatic s_id;
      cmd(8'h90);
      op(K_ADDR_COL, 8'h00);
      op(K_DATA_RD, 8'h00);
      chk(32'(st[15:8]), 32'(mdl.ID0));
      op(K_DATA_RD, 8'h00);
      chk(32'(st[15:8]), 32'(mdl.ID1));
   endtask
   initial begin
      repeat (16) @(posedge i_core_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_core_clk);
      s_reset();
      s_prog();
      s_col();
      s_copy();
      s_guard();
      s_hold();
      s_busy();
      s_erase();
      s_id();
      chk(32'(mdl.viol), 32'h0);
      wrap_up();
   end
endmodule // tb_nand_host
